/* File: rtl/smbcfg_pkg.sv */
// Shared constants and types of the serial configuration access port.
// Assumes a single core clock domain; pins are synchronised inside the port.
package smbcfg_pkg;

  localparam logic [7:0]  CMD_WRITE        = 8'hbe;
  localparam logic [7:0]  CMD_SETUP        = 8'hba;
  localparam logic [7:0]  CMD_READ         = 8'hbd;
  localparam logic [7:0]  CMD_CALL         = 8'hcd;
  localparam logic [7:0]  WR_COUNT         = 8'h08;
  localparam logic [7:0]  SETUP_COUNT      = 8'h04;
  localparam logic [7:0]  RD_COUNT         = 8'h04;
  localparam logic [2:0]  OP_WRITE         = 3'h3;
  localparam logic [2:0]  OP_READ          = 3'h4;
  localparam logic [7:0]  PEC_POLY         = 8'h07;
  localparam logic [7:0]  TX_IDLE_BYTE     = 8'hff;

  // serial_mgmt_control register, upstream port
  localparam logic [4:0]  CTRL_PORT        = 5'h00;
  localparam logic [11:0] CTRL_OFFSET      = 12'h344;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;
  localparam int          CTRL_ADDR_LSB    = 1;
  localparam int          CTRL_ADDR_MSB    = 7;
  localparam int          CTRL_PEC_OFF_BIT = 9;
  localparam logic [3:0]  ADDR_FIXED       = 4'hd;
  localparam logic [1:0]  STRAP_SETTLE     = 2'h2;

  // Byte positions within a write frame and within the read reply
  localparam logic [3:0]  IDX_ADDR         = 4'h0;
  localparam logic [3:0]  IDX_CMD          = 4'h1;
  localparam logic [3:0]  IDX_COUNT        = 4'h2;
  localparam logic [3:0]  IDX_CB1          = 4'h3;
  localparam logic [3:0]  IDX_CB2          = 4'h4;
  localparam logic [3:0]  IDX_CB3          = 4'h5;
  localparam logic [3:0]  IDX_CB4          = 4'h6;
  localparam logic [3:0]  IDX_D1           = 4'h7;
  localparam logic [3:0]  IDX_D4           = 4'ha;
  localparam logic [3:0]  IDX_WR_PEC       = 4'hb;
  localparam logic [3:0]  IDX_SETUP_PEC    = 4'h7;
  localparam logic [2:0]  TX_PEC_IDX       = 3'h5;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RX   = 6'h02,
    ST_RACK = 6'h04,
    ST_TX   = 6'h08,
    ST_TACK = 6'h10,
    ST_WAIT = 6'h20
  } smbcfg_state_type;

endpackage : smbcfg_pkg

/* File: rtl/smbcfg_pec_if.sv */
// Carrier between the port engine and its packet error code unit.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
`default_nettype none
interface smbcfg_pec_if;
  logic       clr;
  logic       stb;
  logic [7:0] din;
  logic [7:0] crc;
  modport core (output clr, output stb, output din, input crc);
  modport calc (input clr, input stb, input din, output crc);
endinterface : smbcfg_pec_if
`default_nettype wire

/* File: rtl/smbcfg_pec.sv */
// Packet error code accumulator, CRC-8 with polynomial x^8+x^2+x+1.
// Assumes clr and stb come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module smbcfg_pec
  import smbcfg_pkg::*;
(
  input  wire logic    core_clk,
  input  wire logic    rstn,
  smbcfg_pec_if.calc   pec
);

  function automatic logic [7:0] smbcfg_crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++)
    begin
      r = r[7] ? ((r << 1) ^ PEC_POLY) : (r << 1);
    end
    return r;
  endfunction : smbcfg_crc8

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      pec.crc <= 8'h00;
    else if (pec.clr)
      pec.crc <= 8'h00;
    else if (pec.stb)
      pec.crc <= smbcfg_crc8(pec.crc, pec.din);
  end

endmodule : smbcfg_pec
`default_nettype wire

/* File: rtl/smbcfg_top.sv */
// Two-wire slave port giving a management master access to configuration registers.
// Assumes scl/sda/strap pins are asynchronous; cfg_* fabric is on core_clk.
//
// Overview of operation
// [R01] Slave only; both wires bidirectional, clock wire never driven by us.
// [R02] Any register reachable, read-only and preloaded ones included, via the fabric.
// [R03] Default address: straps on bits 2:0, bits 6:3 fixed to 1101.
// [R04] Answer the address held in control register bits 7:1, writable by software.
// [R05] Only block write, block read and process call are supported.
// [R06] BEh writes a register; BAh setup then BDh read reads one.
// [R07] Process call with BAh/CDh also returns the selected register.
// [R08] Packet error codes are checked on receive and produced on transmit.
// [R09] Wrong command byte NACKed, with every later byte of the packet.
// [R10] Write count other than 8 NACKed, with all following bytes.
// [R11] Byte after the fourth data byte is the error code, checked when present.
// [R12] Error code mismatch drops the write and NACKs the code byte.
// [R13] Control bit 9 turns error code checking off.
// [R14] Master sends count 08h; the error code byte is never counted.
// [R15] Command byte 1 bits 2:0: 011b writes, 100b reads.
// [R16] Port select: byte 2 bits 3:0 high, byte 3 bit 7 low.
// [R17] Byte 3 bits 5:2 enable bytes; bit 2 low byte, bit 5 high byte.
// [R18] Bit 3 enables bits 15:8, bit 4 bits 23:16; bit 6 ignored.
// [R19] Dword address: byte 3 bits 1:0, byte 4 bits 9:2, low bits zero.
// [R20] Data sent most significant byte first.
// [R21] Write frame order fixed; each accepted byte is acknowledged.
// [R22] Block read returns count 4 then four register bytes.
// [R23] Extra byte after data is the error code; master NACK ends read.
`timescale 1ns/1ps
`default_nettype none
module smbcfg_top
  import smbcfg_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic [2:0]  addr_strap,
  output logic             cfg_req,
  output logic             cfg_we,
  output logic [4:0]       cfg_port,
  output logic [11:0]      cfg_addr,
  output logic [3:0]       cfg_be,
  output logic [31:0]      cfg_wdata,
  input  wire logic [31:0] cfg_rdata,
  input  wire logic        cfg_ack,
  output logic             error_code_check_off
);

  smbcfg_pec_if pec_bus ();

  smbcfg_pec u_pec (
    .core_clk (core_clk),
    .rstn     (rstn),
    .pec      (pec_bus.calc)
  );

  logic [2:0]       scl_s_q;
  logic [2:0]       sda_s_q;
  logic [2:0]       strap_a_q;
  logic [2:0]       strap_b_q;
  logic [1:0]       init_cnt_q;
  logic [31:0]      ctrl_q;
  smbcfg_state_type state_q;
  logic [3:0]       bit_cnt_q;
  logic [7:0]       sh_q;
  logic [7:0]       tx_sh_q;
  logic [7:0]       tx_cur_q;
  logic [2:0]       tx_idx_q;
  logic             mack_q;
  logic             busy_q;
  logic [3:0]       widx_q;
  logic [7:0]       cmd_q;
  logic             bad_q;
  logic             ack_q;
  logic             go_wait_q;
  logic             rd_mode_q;
  logic             rd_ok_q;
  logic [4:0]       port_q;
  logic [11:0]      addr_q;
  logic [3:0]       be_q;
  logic [31:0]      wdata_q;
  logic [31:0]      rdata_q;
  logic             req_q;
  logic             we_q;

  // Only the second stage is read; the third is its delayed copy for edges
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      scl_s_q   <= 3'h7;
      sda_s_q   <= 3'h7;
      strap_a_q <= 3'h0;
      strap_b_q <= 3'h0;
    end
    else
    begin
      scl_s_q   <= {scl_s_q[1:0], scl_i};
      sda_s_q   <= {sda_s_q[1:0], sda_i};
      strap_a_q <= addr_strap;
      strap_b_q <= strap_a_q;
    end
  end

  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic       byte_done;
  logic [7:0] rxb;
  logic       pec_off;
  logic       addr_hit;
  logic       rd_start;
  logic       commit;
  logic       local_hit;
  logic       byte_ok;
  logic       is_setup;

  assign scl_rise  = scl_s_q[1] & ~scl_s_q[2];
  assign scl_fall  = ~scl_s_q[1] & scl_s_q[2];
  assign bus_start = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[1] & sda_s_q[2];
  assign bus_stop  = scl_s_q[1] & scl_s_q[2] & sda_s_q[1] & ~sda_s_q[2];
  assign byte_done = (state_q == ST_RX) && scl_rise && (bit_cnt_q == 4'h7);
  assign rxb       = {sh_q[6:0], sda_s_q[1]};
  assign pec_off   = ctrl_q[CTRL_PEC_OFF_BIT];
  assign addr_hit  = rxb[7:1] == ctrl_q[CTRL_ADDR_MSB:CTRL_ADDR_LSB]; // R04
  assign rd_start  = byte_done && (widx_q == IDX_ADDR) && addr_hit && rxb[0] && rd_ok_q;
  assign commit    = bus_stop && (cmd_q == CMD_WRITE) && (widx_q >= IDX_WR_PEC) && !bad_q;
  assign local_hit = (port_q == CTRL_PORT) && (addr_q == CTRL_OFFSET);
  assign is_setup  = (cmd_q == CMD_SETUP) || (cmd_q == CMD_CALL);

  // Acceptance of the byte just received, by its place in the frame
  always_comb
  begin
    byte_ok = 1'b0;
    case (widx_q)
      IDX_CMD:   byte_ok = (rxb == CMD_WRITE) || (rxb == CMD_SETUP) ||
                           (rxb == CMD_READ) || (rxb == CMD_CALL); // R05 R06 R07
      IDX_COUNT: byte_ok = ((cmd_q == CMD_WRITE) && (rxb == WR_COUNT)) ||
                           (is_setup && (rxb == SETUP_COUNT)); // R10 R14
      IDX_CB1:   byte_ok = rxb[2:0] == ((cmd_q == CMD_WRITE) ? OP_WRITE : OP_READ); // R15
      IDX_CB2, IDX_CB3, IDX_CB4:
                 byte_ok = 1'b1;
      IDX_WR_PEC:
                 byte_ok = (cmd_q == CMD_WRITE) && (pec_off || pec_bus.crc == rxb); // R11 R12 R13
      default:
      begin
        if (widx_q >= IDX_D1 && widx_q <= IDX_D4)
          byte_ok = (cmd_q == CMD_WRITE) ||
                    ((widx_q == IDX_SETUP_PEC) && (pec_off || pec_bus.crc == rxb)); // R11 R13
      end
    endcase
  end

  function automatic logic [7:0] smbcfg_tx_byte(input logic [2:0] idx, input logic [31:0] d,
                                                input logic [7:0] crc);
    case (idx)
      3'h0:       return RD_COUNT; // R22
      3'h1:       return d[31:24]; // R20
      3'h2:       return d[23:16];
      3'h3:       return d[15:8];
      3'h4:       return d[7:0];
      TX_PEC_IDX: return crc; // R23
      default:    return TX_IDLE_BYTE;
    endcase
  endfunction : smbcfg_tx_byte

  logic [7:0] tx_next;
  assign tx_next = smbcfg_tx_byte(3'(tx_idx_q + 3'h1), rdata_q, pec_bus.crc);

  // Bit engine: only sda is ever pulled, scl stays released
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q   <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      sh_q      <= 8'h00;
      tx_sh_q   <= 8'h00;
      tx_cur_q  <= 8'h00;
      tx_idx_q  <= 3'h0;
      mack_q    <= 1'b0;
      sda_oe    <= 1'b0;
    end
    else if (bus_start)
    begin
      state_q   <= ST_RX;
      bit_cnt_q <= 4'h0;
      sda_oe    <= 1'b0;
    end
    else if (bus_stop)
    begin
      state_q <= ST_IDLE;
      sda_oe  <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_RX:
        begin
          if (scl_rise)
          begin
            sh_q      <= rxb;
            bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
          end
          else if (scl_fall && bit_cnt_q == 4'h8)
          begin
            state_q <= ST_RACK;
            sda_oe  <= ack_q; // R21
          end
        end
        ST_RACK:
        begin
          if (scl_fall)
          begin
            bit_cnt_q <= 4'h0;
            if (go_wait_q)
            begin
              state_q <= ST_WAIT;
              sda_oe  <= 1'b0;
            end
            else if (rd_mode_q)
            begin
              state_q  <= ST_TX;
              tx_idx_q <= 3'h0;
              tx_cur_q <= RD_COUNT;
              tx_sh_q  <= {RD_COUNT[6:0], 1'b0};
              sda_oe   <= ~RD_COUNT[7];
            end
            else
            begin
              state_q <= ST_RX;
              sda_oe  <= 1'b0;
            end
          end
        end
        ST_TX:
        begin
          if (scl_fall)
          begin
            bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
            if (bit_cnt_q == 4'h7)
            begin
              state_q <= ST_TACK;
              sda_oe  <= 1'b0;
            end
            else
            begin
              sda_oe  <= ~tx_sh_q[7];
              tx_sh_q <= {tx_sh_q[6:0], 1'b0};
            end
          end
        end
        ST_TACK:
        begin
          if (scl_rise)
            mack_q <= ~sda_s_q[1];
          else if (scl_fall)
          begin
            bit_cnt_q <= 4'h0;
            if (mack_q)
            begin
              state_q  <= ST_TX;
              tx_idx_q <= 3'(tx_idx_q + 3'h1);
              tx_cur_q <= tx_next;
              tx_sh_q  <= {tx_next[6:0], 1'b0};
              sda_oe   <= ~tx_next[7];
            end
            else
              state_q <= ST_WAIT; // R23
          end
        end
        ST_IDLE, ST_WAIT:
          sda_oe <= 1'b0;
        default:
        begin
          state_q <= ST_IDLE;
          sda_oe  <= 1'b0;
        end
      endcase
    end
  end

  // Frame decoding and sticky refusal
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      busy_q    <= 1'b0;
      widx_q    <= IDX_ADDR;
      cmd_q     <= 8'h00;
      bad_q     <= 1'b0;
      ack_q     <= 1'b0;
      go_wait_q <= 1'b0;
      rd_mode_q <= 1'b0;
      rd_ok_q   <= 1'b0;
      port_q    <= 5'h00;
      addr_q    <= 12'h000;
      be_q      <= 4'h0;
      wdata_q   <= 32'h0000_0000;
    end
    else if (bus_start)
    begin
      busy_q    <= 1'b1;
      widx_q    <= IDX_ADDR;
      rd_mode_q <= 1'b0;
      if (!busy_q)
      begin
        cmd_q <= 8'h00;
        bad_q <= 1'b0;
      end
    end
    else if (bus_stop)
      busy_q <= 1'b0;
    else if (byte_done)
    begin
      if (widx_q == IDX_ADDR)
      begin
        ack_q     <= addr_hit && (!rxb[0] || rd_ok_q); // R01
        go_wait_q <= !addr_hit || (rxb[0] && !rd_ok_q);
        rd_mode_q <= rd_start; // R22
        if (addr_hit && !rxb[0])
          widx_q <= IDX_CMD;
      end
      else
      begin
        go_wait_q <= 1'b0;
        ack_q     <= byte_ok && !bad_q; // R09
        if (!byte_ok)
          bad_q <= 1'b1; // R09 R10 R12
        if (widx_q != 4'hf)
          widx_q <= 4'(widx_q + 4'h1);
        if (widx_q == IDX_CMD)
        begin
          cmd_q <= rxb;
          if (rxb != CMD_READ)
            rd_ok_q <= 1'b0;
        end
        if (widx_q == IDX_CB2)
          port_q[4:1] <= rxb[3:0]; // R16
        if (widx_q == IDX_CB3)
        begin
          port_q[0]     <= rxb[7]; // R16
          be_q          <= rxb[5:2]; // R17 R18
          addr_q[11:10] <= rxb[1:0]; // R19
        end
        if (widx_q == IDX_CB4)
        begin
          addr_q[9:0] <= {rxb, 2'b00}; // R19
          if (is_setup && !bad_q)
            rd_ok_q <= 1'b1; // R06 R07
        end
        if (widx_q >= IDX_D1 && widx_q <= IDX_D4 && cmd_q == CMD_WRITE)
          wdata_q <= {wdata_q[23:0], rxb}; // R20
        if (widx_q == IDX_SETUP_PEC && is_setup && !byte_ok)
          rd_ok_q <= 1'b0;
      end
    end
  end

  // Fabric handshake; control register accesses still go to the fabric, reads return ctrl_q once cfg_ack arrives
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      req_q   <= 1'b0;
      we_q    <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else if (req_q)
    begin
      if (cfg_ack)
      begin
        req_q <= 1'b0;
        if (!we_q)
          rdata_q <= local_hit ? ctrl_q : cfg_rdata; // R02
      end
    end
    else if (commit)
    begin
      req_q <= 1'b1; // R02 R21
      we_q  <= 1'b1;
    end
    else if (rd_start)
    begin
      req_q <= 1'b1;
      we_q  <= 1'b0;
    end
  end

  // Straps caught once they have crossed, never under reset itself
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      init_cnt_q <= 2'h0;
      ctrl_q     <= CTRL_RESET;
    end
    else if (init_cnt_q != 2'h3)
    begin
      init_cnt_q <= 2'(init_cnt_q + 2'h1);
      if (init_cnt_q == STRAP_SETTLE)
        ctrl_q[CTRL_ADDR_MSB:CTRL_ADDR_LSB] <= {ADDR_FIXED, strap_b_q}; // R03
    end
    else if (commit && local_hit)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (be_q[i])
          ctrl_q[i*8 +: 8] <= wdata_q[i*8 +: 8]; // R04 R17 R18
      end
    end
  end

  assign pec_bus.clr = bus_start && !busy_q; // R08
  assign pec_bus.stb = byte_done || (state_q == ST_TX && scl_fall && bit_cnt_q == 4'h7);
  assign pec_bus.din = byte_done ? rxb : tx_cur_q;

  assign scl_o                = 1'b0;
  assign scl_oe               = 1'b0; // R01
  assign sda_o                = 1'b0;
  assign cfg_req              = req_q;
  assign cfg_we               = we_q;
  assign cfg_port             = port_q;
  assign cfg_addr             = addr_q;
  assign cfg_be               = be_q;
  assign cfg_wdata            = wdata_q;
  assign error_code_check_off = pec_off; // R13

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  AST_SCL_RELEASED: assert property (!scl_oe && (!sda_oe || state_q == ST_RACK || state_q == ST_TX)) // R01
    else $error("wire driven outside own turn");
  AST_ADDR_MISS_WAITS: assert property ( // R04
    byte_done && widx_q == IDX_ADDR && !addr_hit |=> !ack_q ##0 go_wait_q)
    else $error("foreign address not ignored");
  AST_BAD_COUNT_NACK: assert property ( // R10
    byte_done && widx_q == IDX_COUNT && cmd_q == CMD_WRITE && rxb != WR_COUNT |=> !ack_q && bad_q)
    else $error("bad count acknowledged");
  AST_BAD_STICKY: assert property (bad_q && !(bus_start && !busy_q) |=> bad_q) // R09
    else $error("refusal not sticky");
  AST_PEC_MISMATCH: assert property ( // R12
    byte_done && widx_q == IDX_WR_PEC && cmd_q == CMD_WRITE && !pec_off && pec_bus.crc != rxb
    |=> !ack_q ##0 bad_q)
    else $error("bad error code accepted");
  AST_NACK_RELEASED: assert property (state_q == ST_RACK && !ack_q |-> !sda_oe) // R09
    else $error("nack drives data");
  AST_WRITE_ONLY_BEH: assert property ($rose(cfg_req) && cfg_we |-> $past(cmd_q) == CMD_WRITE) // R06
    else $error("write without write command");
  AST_REQ_HOLDS: assert property (cfg_req && !cfg_ack |=> cfg_req && $stable(cfg_we)) // R02
    else $error("request dropped early");
  AST_READ_COUNT: assert property ( // R22
    state_q == ST_RACK && scl_fall && rd_mode_q && !go_wait_q && !bus_start && !bus_stop
    |=> state_q == ST_TX && tx_cur_q == RD_COUNT)
    else $error("read does not start with count");

  COV_WRITE: cover property ($rose(cfg_req) && cfg_we);
  COV_READ: cover property ($rose(cfg_req) && !cfg_we);
  COV_PEC_SENT: cover property (state_q == ST_TX && tx_idx_q == TX_PEC_IDX);
  COV_REFUSED: cover property ($rose(bad_q));

endmodule : smbcfg_top
`default_nettype wire

/* File: verification/smbcfg_master_model.sv */
// Behavioural management master that drives the two-wire link.
// Assumes pull-ups on both wires; the bench resolves the data wire.
`timescale 1ns/1ps
`default_nettype none
module smbcfg_master_model
(
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  localparam int Q = 40;

  // Clock stands high between frames
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic start();
    #Q sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
  endtask : start

  task automatic stop();
    #Q sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #Q;
  endtask : stop

  // Data changes only while the clock is low
  task automatic bit_io(input logic b, output logic v);
    #Q sda_low = ~b;
    #Q scl = 1'b1;
    #Q v = sda;
    #Q scl = 1'b0;
  endtask : bit_io

  task automatic put(input logic [7:0] d, output logic nak);
    logic v;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], v);
    bit_io(1'b1, nak);
  endtask : put

  task automatic get(input logic nak, output logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(nak, nak);
  endtask : get
endmodule : smbcfg_master_model
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench for the two-wire configuration access port.
// Assumes the master model is compiled first; the fabric is modelled here.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import smbcfg_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        cfg_ack = 1'b0;
  logic [2:0]  addr_strap;
  logic [31:0] cfg_rdata = 32'h0;
  logic [31:0] rd_val, d, cfg_wdata;
  logic        scl_o, scl_oe, sda_o, sda_oe, cfg_req, cfg_we, error_code_check_off;
  logic [4:0]  cfg_port, p;
  logic [11:0] cfg_addr, a;
  logic [3:0]  cfg_be, be;
  logic [53:0] cap;
  logic [7:0]  fb [0:11];
  logic        ak [0:11];
  logic [7:0]  crc;
  logic [6:0]  dev, old;
  int          failures = 0;
  int          n_tests = 0;
  int          n_req = 0;
  int          n0, cyc = 0;
  int          bad_i [5] = '{0, 1, 2, 3, 11};
  logic [7:0]  bad_x [5] = '{8'h02, 8'h01, 8'h0f, 8'h07, 8'h01};
  wire         scl_w, sda_w, m_scl, m_low;

  assign scl_w = (scl_oe ? scl_o : 1'b1) & m_scl;
  assign sda_w = (sda_oe ? sda_o : 1'b1) & ~m_low;

  smbcfg_top dut (.core_clk, .rstn, .scl_i(scl_w), .scl_o, .scl_oe, .sda_i(sda_w), .sda_o,
    .sda_oe, .addr_strap, .cfg_req, .cfg_we, .cfg_port, .cfg_addr, .cfg_be, .cfg_wdata,
    .cfg_rdata, .cfg_ack, .error_code_check_off);
  smbcfg_master_model m (.scl(m_scl), .sda_low(m_low), .sda(sda_w));

  always #5 core_clk = ~core_clk;

  // Fabric answers well before the read count byte ends
  initial
  forever
  begin
    @(posedge core_clk);
    #1;
    if (cfg_req === 1'b1)
    begin
      n_req++;
      cap = {cfg_we, cfg_port, cfg_addr, cfg_be, cfg_wdata};
      cfg_rdata = rd_val;
      repeat ($urandom_range(6, 1)) @(posedge core_clk);
      #1 cfg_ack = 1'b1;
      @(posedge core_clk);
      #1 cfg_ack = 1'b0;
    end
  end

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      failures++;
      final_report();
    end
  end

  task automatic final_report();
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  function automatic logic [7:0] crc_upd(logic [7:0] c, logic [7:0] b);
    c = c ^ b;
    for (int i = 0; i < 8; i++)
      c = c[7] ? {c[6:0], 1'b0} ^ PEC_POLY : {c[6:0], 1'b0};
    return c;
  endfunction : crc_upd

  task automatic rnd();
    p = 5'($urandom_range(5, 1));
    be = 4'($urandom);
    a = 12'($urandom) & 12'hffc;
    d = $urandom;
  endtask : rnd

  task automatic mk(logic [7:0] c, logic [7:0] n, logic [2:0] op, logic [4:0] pt,
                    logic [3:0] e, logic [11:0] ad, logic [31:0] dt);
    {fb[0], fb[1], fb[2], fb[3], fb[4], fb[5], fb[6], fb[7], fb[8], fb[9], fb[10]} =
      {dev, 1'b0, c, n, 5'h0, op, 4'h0, pt[4:1], pt[0], 1'b0, e, ad[11:10], ad[9:2], dt};
    fb[11] = 8'h00;
    for (int i = 0; i < 11; i++)
      fb[11] = crc_upd(fb[11], fb[i]);
  endtask : mk

  task automatic wait_idle();
    repeat (20) @(posedge core_clk);
    #1;
  endtask : wait_idle

  // Every fresh start restarts the error code
  task automatic send(int n, bit stp);
    crc = 8'h00;
    m.start();
    for (int i = 0; i < n; i++)
    begin
      m.put(fb[i], ak[i]);
      crc = crc_upd(crc, fb[i]);
    end
    if (stp)
    begin
      m.stop();
      wait_idle();
    end
  endtask : send

  task automatic chk_ak(int n, int bad);
    for (int i = 0; i < n; i++)
      chk("ack", ak[i], i >= bad);
  endtask : chk_ak

  task automatic rd_part(logic [31:0] exp, int nb);
    logic [7:0] b, e;
    logic       nk;
    m.start();
    m.put({dev, 1'b1}, nk);
    chk("rd_addr_ack", nk, 1'b0);
    crc = crc_upd(crc, {dev, 1'b1});
    for (int i = 0; i < nb; i++)
    begin
      m.get(i == nb - 1, b);
      e = i == 0 ? RD_COUNT : i == 5 ? crc : exp[8 * (4 - i) +: 8];
      chk("rd_byte", b, e);
      crc = crc_upd(crc, e);
    end
    m.stop();
    wait_idle();
    chk("rd_end", sda_oe, 1'b0);
  endtask : rd_part

  initial
  begin
    void'($urandom(32'h2db3));
    addr_strap = 3'($urandom);
    rd_val = $urandom;
    dev = {4'hd, addr_strap};
    repeat (2) @(posedge core_clk);
    #1;
    chk("rst", {sda_oe, scl_oe, cfg_req, error_code_check_off}, 4'h0);
    $display("reset test done");
    rstn = 1'b1;
    repeat (6) @(posedge core_clk);
    #1;
    for (int k = 0; k < 4; k++)
    begin
      rnd();
      mk(CMD_WRITE, WR_COUNT, OP_WRITE, p, be, a, d);
      n0 = n_req;
      send(k == 3 ? 11 : 12, 1);
      chk_ak(k == 3 ? 11 : 12, 12);
      chk("wr_req", n_req, n0 + 1);
      chk("wr", cap, {1'b1, p, a, be, d});
      $display("write test %0d done", k);
    end
    for (int k = 0; k < 5; k++)
    begin
      rnd();
      mk(CMD_WRITE, WR_COUNT, OP_WRITE, p, be, a, d);
      fb[bad_i[k]] = fb[bad_i[k]] ^ bad_x[k];
      n0 = n_req;
      send(12, 1);
      chk_ak(12, bad_i[k]);
      chk("no_req", n_req, n0);
      $display("refusal test %0d done", k);
    end
    for (int k = 0; k < 2; k++)
    begin
      rnd();
      rd_val = $urandom;
      mk(k ? CMD_CALL : CMD_SETUP, SETUP_COUNT, OP_READ, p, 4'hf, a, 32'h0);
      // Process call carries an error code on its setup half
      fb[7] = 8'h00;
      for (int i = 0; i < 7; i++)
        fb[7] = crc_upd(fb[7], fb[i]);
      send(7 + k, k == 0);
      chk_ak(7 + k, 12);
      if (k == 0)
      begin
        fb[1] = CMD_READ;
        send(2, 0);
        chk_ak(2, 12);
      end
      rd_part(rd_val, 6);
      chk("rd_req", cap[53:36], {1'b0, p, a});
      $display("read test %0d done", k);
    end
    mk(CMD_WRITE, WR_COUNT, OP_WRITE, 5'h0, 4'h3, 12'h344, 32'h0000_0254);
    send(12, 1);
    chk("check_off", error_code_check_off, 1'b1);
    old = dev;
    dev = 7'h2a;
    rnd();
    mk(CMD_WRITE, WR_COUNT, OP_WRITE, p, be, a, d);
    fb[11] = fb[11] ^ 8'h01;
    n0 = n_req;
    send(12, 1);
    chk_ak(12, 12);
    chk("pec_off_req", n_req, n0 + 1);
    fb[0] = {old, 1'b0};
    send(1, 1);
    chk_ak(1, 0);
    mk(CMD_CALL, SETUP_COUNT, OP_READ, 5'h0, 4'hf, 12'h344, 32'h0);
    send(7, 0);
    chk_ak(7, 12);
    rd_part(32'h0000_0254, 5);
    $display("control test done");
    final_report();
  end
endmodule : tb_top
`default_nettype wire
